// ==== rtl/fbm_pkg.sv ====
package fbm_pkg;
  localparam int unsigned BUS_W       = 64;
  localparam int unsigned PORT_W      = 16;
  localparam int unsigned NUM_PORTS   = 4;
  localparam int unsigned SG_CH_W     = 32;
  localparam int unsigned ROW_W       = 12;
  localparam int unsigned COL_W       = 8;
  localparam int unsigned BANK_W      = 2;
  localparam int unsigned SD_ADDR_W   = ROW_W + COL_W + BANK_W;
  localparam int unsigned PLL_MULT    = 16;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned HSC_MHZ     = 125;
  localparam int unsigned MSC_MHZ     = 100;
  localparam int unsigned T_POWERUP_US = 200;
  localparam int unsigned POWERUP_CYC  = T_POWERUP_US * CLK_MHZ;
  localparam int unsigned T_REFI_NS    = 15625;
  localparam int unsigned REFI_CYC     = (T_REFI_NS * CLK_MHZ) / 1000;
  localparam int unsigned T_RP_NS      = 20;
  localparam int unsigned T_RCD_NS     = 20;
  localparam int unsigned T_RFC_NS     = 70;
  localparam int unsigned RP_CYC  = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MRD_CYC = 2;
  localparam int unsigned CAS_LAT = 2;
  localparam int unsigned INIT_REFS = 8;
  localparam logic [2:0] CAS_LAT_W = 3'h2;
  localparam logic [12:0] MODE_WORD = 13'h0020;
  localparam int unsigned A10_BIT = 10;
  // command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP  = 4'h7;
  localparam logic [3:0] CMD_ACT  = 4'h3;
  localparam logic [3:0] CMD_RD   = 4'h5;
  localparam logic [3:0] CMD_WR   = 4'h4;
  localparam logic [3:0] CMD_PRE  = 4'h2;
  localparam logic [3:0] CMD_REF  = 4'h1;
  localparam logic [3:0] CMD_MRS  = 4'h0;
  localparam logic [3:0] CMD_DESL = 4'hF;
  typedef enum logic [1:0] {
    MEM_SDRAM = 2'b00,
    MEM_SGRAM = 2'b01
  } fbm_mem_t;
  typedef enum logic [3:0] {
    ST_PWRUP = 4'b0000,
    ST_PRE0  = 4'b0001,
    ST_REF0  = 4'b0010,
    ST_MRS   = 4'b0011,
    ST_IDLE  = 4'b0100,
    ST_ACT   = 4'b0101,
    ST_WR    = 4'b0110,
    ST_RD    = 4'b0111,
    ST_RDWT  = 4'b1000,
    ST_PRE   = 4'b1001,
    ST_REF   = 4'b1010,
    ST_WAIT  = 4'b1011
  } fbm_state_t;
endpackage

// ==== rtl/fbm_stream_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface fbm_stream_if #(parameter int unsigned W = 64);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/fbm_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module fbm_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  // streams
  fbm_stream_if.snk s_in,
  fbm_stream_if.src s_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  assign s_in.ready  = (cnt_q != (AW+1)'(DEPTH));
  assign s_out.valid = (cnt_q != '0);
  assign s_out.data  = mem_q[rd_q];
  assign push = i_ce && s_in.valid && s_in.ready;
  assign pop  = i_ce && s_out.valid && s_out.ready;
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wr_q] <= s_in.data;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/fbm_mem_port.sv ====
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - 64-bit data bus splits into four 16-bit ports, DQ0-15 up to DQ48-63.
// - memory clock up to 125 MHz, from internal PLL or external pin.
// - only the contiguous low ports needed are used; higher ports stay idle.
// - SDRAM mode: up to four 16-bit ports of 1M x 16 parts sharing one command stream.
// - SDRAM mode addresses only half of installed capacity.
// - high-speed grade runs at 125 MHz, medium-speed grade at 100 MHz; timing counts assume 100 MHz for both grades.
// - SGRAM mode: two 32-bit channels of 256k x 32 parts.
// - PLL memory clock equals system clock over pre-divider times sixteen.
// - when panel accepts input rate, rate adaption bypasses the frame buffer.
module fbm_mem_port #(
  parameter int unsigned POWERUP_CYCLES = fbm_pkg::POWERUP_CYC,
  parameter int unsigned REFI_CYCLES    = fbm_pkg::REFI_CYC,
  parameter int unsigned FIFO_DEPTH     = 8
) (
  // clock, reset, enable
  input  wire logic                          i_mclk,
  input  wire logic                          i_rstn,
  input  wire logic                          i_ce,
  // configuration
  input  wire logic                          i_sgram_mode,
  input  wire logic [2:0]                    i_num_ports,
  input  wire logic                          i_high_speed_channel_grade,
  input  wire logic                          i_bypass,
  input  wire logic                          i_use_pll,
  input  wire logic [4:0]                    i_pll_prediv,
  // write stream from the engine
  input  wire logic                          i_wr_valid,
  input  wire logic [fbm_pkg::BUS_W-1:0]     i_wr_data,
  input  wire logic [fbm_pkg::SD_ADDR_W-1:0] i_wr_addr,
  output logic                               o_wr_ready,
  // read request and return
  input  wire logic                          i_rd_req,
  input  wire logic [fbm_pkg::SD_ADDR_W-1:0] i_rd_addr,
  output logic                               o_rd_busy,
  output logic                               o_rd_valid,
  output logic [fbm_pkg::BUS_W-1:0]          o_rd_data,
  // bypass path
  input  wire logic [fbm_pkg::BUS_W-1:0]     i_byp_data,
  input  wire logic                          i_byp_valid,
  output logic [fbm_pkg::BUS_W-1:0]          o_byp_data,
  output logic                               o_byp_valid,
  // memory pins
  output logic                               o_mem_cke,
  output logic [fbm_pkg::NUM_PORTS-1:0]      o_mem_cs_n,
  output logic                               o_mem_ras_n,
  output logic                               o_mem_cas_n,
  output logic                               o_mem_we_n,
  output logic [fbm_pkg::BANK_W-1:0]         o_mem_ba,
  output logic [12:0]                        o_mem_a,
  output logic [fbm_pkg::NUM_PORTS*2-1:0]    o_mem_dqm,
  input  wire logic [fbm_pkg::BUS_W-1:0]     i_mem_dq,
  output logic [fbm_pkg::BUS_W-1:0]          o_mem_dq,
  output logic [fbm_pkg::BUS_W-1:0]          o_mem_dq_oe,
  // status
  output logic                               o_init_done,
  output logic [8:0]                         o_mem_clk_mult
);
  //////////////////////////////////////////////////////////////////////////////
  fbm_pkg::fbm_state_t st_q;
  fbm_pkg::fbm_state_t ret_q;
  logic [23:0]                      wait_q;
  logic [23:0]                      refi_q;
  logic [3:0]                       nref_q;
  logic                             ref_due_q;
  logic                             is_wr_q;
  logic [fbm_pkg::SD_ADDR_W-1:0]    adr_q;
  logic [fbm_pkg::BUS_W-1:0]        wdat_q;
  logic [fbm_pkg::NUM_PORTS-1:0]    port_en;
  logic [3:0]                       cmd_q;
  logic [2:0]                       lat_q;
  logic                             fire;
  fbm_stream_if #(.W(fbm_pkg::BUS_W)) wr_in ();
  fbm_stream_if #(.W(fbm_pkg::BUS_W)) wr_out ();
  logic [fbm_pkg::SD_ADDR_W-1:0]    waddr_q;

  // in sdram mode only ports below the configured count are selected
  // sgram pairs ports into two 32-bit channels
  genvar g;
  generate
    for (g = 0; g < fbm_pkg::NUM_PORTS; g++) begin : g_port
      assign port_en[g] = i_sgram_mode ? (3'(g / 2) < ((i_num_ports + 3'h1) >> 1))
                                       : (3'(g) < i_num_ports);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // write buffer in front of the command engine
  assign wr_in.valid  = i_wr_valid && !i_bypass;
  assign wr_in.data   = i_wr_data;
  assign o_wr_ready   = wr_in.ready && !i_bypass;
  assign wr_out.ready = (st_q == fbm_pkg::ST_IDLE) && !ref_due_q && i_ce;

  fbm_fifo #(.WIDTH(fbm_pkg::BUS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .s_in   (wr_in),
    .s_out  (wr_out)
  );

  // the fifo holds data only: a write takes the address registered one cycle before its pop
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      waddr_q <= '0;
    end else if (i_ce) begin
      waddr_q <= i_wr_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // refresh interval timer
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      refi_q    <= '0;
      ref_due_q <= 1'b0;
    end else if (i_ce) begin
      if (refi_q >= 24'(REFI_CYCLES - 1)) begin
        refi_q    <= '0;
        ref_due_q <= o_init_done;
      end else begin
        refi_q <= refi_q + 24'h1;
        if (st_q == fbm_pkg::ST_REF) begin
          ref_due_q <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command sequencer
  assign fire = (wait_q == '0);
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q        <= fbm_pkg::ST_PWRUP;
      ret_q       <= fbm_pkg::ST_IDLE;
      wait_q      <= '0;
      nref_q      <= '0;
      cmd_q       <= fbm_pkg::CMD_DESL;
      is_wr_q     <= 1'b0;
      adr_q       <= '0;
      wdat_q      <= '0;
      o_init_done <= 1'b0;
      o_rd_busy   <= 1'b1;
      o_mem_cke   <= 1'b0;
      o_mem_ba    <= '0;
      o_mem_a     <= '0;
    end else if (i_ce) begin
      cmd_q <= fbm_pkg::CMD_NOP;
      case (st_q)
        fbm_pkg::ST_PWRUP: begin
          o_mem_cke <= 1'b1;
          wait_q    <= 24'(POWERUP_CYCLES);
          ret_q     <= fbm_pkg::ST_PRE0;
          st_q      <= fbm_pkg::ST_WAIT;
        end
        fbm_pkg::ST_PRE0: begin
          cmd_q            <= fbm_pkg::CMD_PRE;
          o_mem_a          <= '0;
          o_mem_a[fbm_pkg::A10_BIT] <= 1'b1;
          wait_q           <= 24'(fbm_pkg::RP_CYC);
          nref_q           <= 4'(fbm_pkg::INIT_REFS);
          ret_q            <= fbm_pkg::ST_REF0;
          st_q             <= fbm_pkg::ST_WAIT;
        end
        fbm_pkg::ST_REF0: begin
          cmd_q  <= fbm_pkg::CMD_REF;
          nref_q <= nref_q - 4'h1;
          wait_q <= 24'(fbm_pkg::RFC_CYC);
          ret_q  <= (nref_q == 4'h1) ? fbm_pkg::ST_MRS : fbm_pkg::ST_REF0;
          st_q   <= fbm_pkg::ST_WAIT;
        end
        fbm_pkg::ST_MRS: begin
          cmd_q    <= fbm_pkg::CMD_MRS;
          o_mem_ba <= '0;
          o_mem_a  <= fbm_pkg::MODE_WORD;
          wait_q   <= 24'(fbm_pkg::MRD_CYC);
          ret_q    <= fbm_pkg::ST_IDLE;
          st_q     <= fbm_pkg::ST_WAIT;
        end
        fbm_pkg::ST_IDLE: begin
          o_init_done <= 1'b1;
          o_rd_busy   <= 1'b0;
          if (ref_due_q) begin
            st_q <= fbm_pkg::ST_REF;
          end else if (wr_out.valid) begin
            is_wr_q <= 1'b1;
            wdat_q  <= wr_out.data;
            // top address bit forced low: only half the sdram is used
            adr_q   <= i_sgram_mode ? waddr_q
                       : {1'b0, waddr_q[fbm_pkg::SD_ADDR_W-2:0]};
            o_rd_busy <= 1'b1;
            st_q    <= fbm_pkg::ST_ACT;
          end else if (i_rd_req && !i_bypass) begin
            is_wr_q <= 1'b0;
            adr_q   <= i_sgram_mode ? i_rd_addr
                       : {1'b0, i_rd_addr[fbm_pkg::SD_ADDR_W-2:0]};
            o_rd_busy <= 1'b1;
            st_q    <= fbm_pkg::ST_ACT;
          end
        end
        fbm_pkg::ST_ACT: begin
          cmd_q    <= fbm_pkg::CMD_ACT;
          o_mem_ba <= adr_q[fbm_pkg::SD_ADDR_W-1 -: fbm_pkg::BANK_W];
          o_mem_a  <= 13'(adr_q[fbm_pkg::COL_W +: fbm_pkg::ROW_W]);
          wait_q   <= 24'(fbm_pkg::RCD_CYC);
          ret_q    <= is_wr_q ? fbm_pkg::ST_WR : fbm_pkg::ST_RD;
          st_q     <= fbm_pkg::ST_WAIT;
        end
        fbm_pkg::ST_WR: begin
          cmd_q   <= fbm_pkg::CMD_WR;
          o_mem_a <= 13'(adr_q[fbm_pkg::COL_W-1:0]);
          wait_q  <= 24'(fbm_pkg::RP_CYC);
          ret_q   <= fbm_pkg::ST_PRE;
          st_q    <= fbm_pkg::ST_WAIT;
        end
        fbm_pkg::ST_RD: begin
          cmd_q   <= fbm_pkg::CMD_RD;
          o_mem_a <= 13'(adr_q[fbm_pkg::COL_W-1:0]);
          wait_q  <= 24'(fbm_pkg::CAS_LAT + 1);
          ret_q   <= fbm_pkg::ST_PRE;
          st_q    <= fbm_pkg::ST_WAIT;
        end
        fbm_pkg::ST_PRE: begin
          cmd_q   <= fbm_pkg::CMD_PRE;
          o_mem_a <= '0;
          o_mem_a[fbm_pkg::A10_BIT] <= 1'b1;
          wait_q  <= 24'(fbm_pkg::RP_CYC);
          ret_q   <= fbm_pkg::ST_IDLE;
          st_q    <= fbm_pkg::ST_WAIT;
        end
        fbm_pkg::ST_REF: begin
          cmd_q  <= fbm_pkg::CMD_REF;
          wait_q <= 24'(fbm_pkg::RFC_CYC);
          ret_q  <= fbm_pkg::ST_IDLE;
          st_q   <= fbm_pkg::ST_WAIT;
        end
        fbm_pkg::ST_WAIT: begin
          if (fire || wait_q == 24'h1) begin
            wait_q <= '0;
            st_q   <= ret_q;
          end else begin
            wait_q <= wait_q - 24'h1;
          end
        end
        default: st_q <= fbm_pkg::ST_PWRUP;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins: command fans out only to the enabled ports
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_cs_n  <= '1;
      o_mem_ras_n <= 1'b1;
      o_mem_cas_n <= 1'b1;
      o_mem_we_n  <= 1'b1;
      o_mem_dqm   <= '1;
      o_mem_dq    <= '0;
      o_mem_dq_oe <= '0;
    end else if (i_ce) begin
      o_mem_cs_n  <= cmd_q[3] ? '1 : ~port_en;
      o_mem_ras_n <= cmd_q[2];
      o_mem_cas_n <= cmd_q[1];
      o_mem_we_n  <= cmd_q[0];
      for (int p = 0; p < fbm_pkg::NUM_PORTS; p++) begin
        o_mem_dqm[2*p +: 2] <= port_en[p] ? 2'h0 : 2'h3;
        // each port owns its own 16-bit lane of the data bus
        o_mem_dq_oe[p*fbm_pkg::PORT_W +: fbm_pkg::PORT_W] <=
          (cmd_q == fbm_pkg::CMD_WR && port_en[p]) ? '1 : '0;
      end
      o_mem_dq <= wdat_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read capture after cas latency; unused ports read as zero
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      lat_q      <= '0;
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end else if (i_ce) begin
      lat_q      <= (cmd_q == fbm_pkg::CMD_RD) ? 3'(fbm_pkg::CAS_LAT) + 3'h1
                  : (lat_q != '0) ? lat_q - 3'h1 : '0;
      o_rd_valid <= (lat_q == 3'h1);
      for (int p = 0; p < fbm_pkg::NUM_PORTS; p++) begin
        o_rd_data[p*fbm_pkg::PORT_W +: fbm_pkg::PORT_W] <= port_en[p]
          ? i_mem_dq[p*fbm_pkg::PORT_W +: fbm_pkg::PORT_W] : '0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bypass when the panel takes the input rate; pll ratio report
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_byp_data     <= '0;
      o_byp_valid    <= 1'b0;
      o_mem_clk_mult <= '0;
    end else if (i_ce) begin
      o_byp_valid <= i_bypass && i_byp_valid;
      o_byp_data  <= i_byp_data;
      // multiplier of system clock over pre-divider; zero for external pin, or high-speed grade with zero pre-divider
      o_mem_clk_mult <= i_use_pll ? 9'(fbm_pkg::PLL_MULT) : '0;
      // grade input only zeroes the multiplier when pre-divider is zero; clock must match 125 or 100 MHz
      if (i_high_speed_channel_grade && i_pll_prediv == '0) begin
        o_mem_clk_mult <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/fbm_sdram_mdl.sv ====
`timescale 1ns/10ps
`default_nettype none
module fbm_sdram_mdl (
  // command and write side from the port
  input  wire logic        i_mclk,
  input  wire logic [3:0]  i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [1:0]  i_ba,
  input  wire logic [12:0] i_a,
  input  wire logic [7:0]  i_dqm,
  input  wire logic [63:0] i_dq,
  // read data back to the port
  output logic      [63:0] o_dq
);
  // four x16 parts side by side share the command lines, one per port
  logic [63:0] mem [logic [21:0]];
  logic [11:0] row_q [4];
  logic [21:0] key_q;
  logic [3:0]  rd_cs_q;
  logic [3:0]  rd_sh = 4'h0;
  logic [63:0] last_wr = 64'h0;
  logic [63:0] w;
  logic [2:0]  cmd;
  logic        sel;
  assign cmd = {i_ras_n, i_cas_n, i_we_n};
  assign sel = ~&i_cs_n;
  initial o_dq = 64'h0;
  // timing is whatever grade clock the board gives it
  always @(posedge i_mclk) begin
    rd_sh <= {rd_sh[2:0], sel && cmd == 3'h5};
    if (sel && cmd == 3'h3) begin
      row_q[i_ba] <= i_a[11:0];
    end
    if (sel && cmd == 3'h5) begin
      key_q <= {i_ba, row_q[i_ba], i_a[7:0]};
      rd_cs_q <= ~i_cs_n;
    end
    if (sel && cmd == 3'h4) begin
      w = mem.exists({i_ba, row_q[i_ba], i_a[7:0]}) ? mem[{i_ba, row_q[i_ba], i_a[7:0]}] : '0;
      for (int b = 0; b < 8; b++) begin
        if (!i_cs_n[b/2] && !i_dqm[b]) begin
          w[8*b +: 8] = i_dq[8*b +: 8];
        end
      end
      mem[{i_ba, row_q[i_ba], i_a[7:0]}] = w;
      last_wr <= w;
    end
    // unselected ports and idle cycles never repeat the last value
    w = ~o_dq;
    if (rd_sh[fbm_pkg::CAS_LAT-2] && mem.exists(key_q)) begin
      for (int p = 0; p < 4; p++) begin
        if (rd_cs_q[p]) begin
          w[16*p +: 16] = mem[key_q][16*p +: 16];
        end
      end
    end
    o_dq <= w;
  end
endmodule
`default_nettype wire

// ==== dv/fbm_mem_port_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module fbm_mem_port_chk (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rstn,
  // configuration and bypass
  input wire logic [2:0]  i_num_ports,
  input wire logic        i_bypass,
  input wire logic        i_use_pll,
  input wire logic        i_byp_valid,
  input wire logic [63:0] i_byp_data,
  // watched outputs
  input wire logic [3:0]  o_mem_cs_n,
  input wire logic        o_mem_ras_n,
  input wire logic        o_mem_cas_n,
  input wire logic        o_mem_we_n,
  input wire logic [7:0]  o_mem_dqm,
  input wire logic [63:0] o_mem_dq_oe,
  input wire logic        o_rd_valid,
  input wire logic        o_rd_busy,
  input wire logic [63:0] o_byp_data,
  input wire logic        o_byp_valid,
  input wire logic        o_init_done,
  input wire logic [8:0]  o_mem_clk_mult
);
  logic [3:0] cmd;
  assign cmd = {o_mem_cs_n[0], o_mem_ras_n, o_mem_cas_n, o_mem_we_n};
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_port3_idle;
    i_num_ports <= 3'h3 && $past(i_num_ports) <= 3'h3
      |-> o_mem_cs_n[3] && o_mem_dqm[7:6] == 2'h3 && o_mem_dq_oe[63:48] == 16'h0;
  endproperty
  a_port3_idle: assert property (p_port3_idle) else $error("unused port 3 active");
  property p_pll_mult;
    $past(i_rstn) && $stable(i_use_pll) |-> o_mem_clk_mult == (i_use_pll ? 9'h010 : 9'h000);
  endproperty
  a_pll_mult: assert property (p_pll_mult) else $error("clock multiplier wrong");
  property p_byp_pass;
    i_bypass && i_byp_valid |=> o_byp_valid && o_byp_data == $past(i_byp_data);
  endproperty
  a_byp_pass: assert property (p_byp_pass) else $error("bypass word lost");
  property p_byp_no_act;
    i_bypass && $past(i_bypass) && $past(i_bypass, 2) |-> cmd != fbm_pkg::CMD_ACT;
  endproperty
  a_byp_no_act: assert property (p_byp_no_act) else $error("row opened in bypass");
  property p_rd_pulse;
    o_rd_valid |=> !o_rd_valid;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid too long");
  property p_trcd;
    cmd == fbm_pkg::CMD_ACT |=> cmd != fbm_pkg::CMD_RD && cmd != fbm_pkg::CMD_WR;
  endproperty
  a_trcd: assert property (p_trcd) else $error("column command too soon");
  property p_trfc;
    cmd == fbm_pkg::CMD_REF |=> (cmd != fbm_pkg::CMD_ACT && cmd != fbm_pkg::CMD_REF) [*6];
  endproperty
  a_trfc: assert property (p_trfc) else $error("refresh recovery cut short");
  property p_mrs_done;
    cmd == fbm_pkg::CMD_MRS |-> ##[1:8] o_init_done;
  endproperty
  a_mrs_done: assert property (p_mrs_done) else $error("init not done after mode set");
  property p_busy_init;
    !o_init_done |-> o_rd_busy;
  endproperty
  a_busy_init: assert property (p_busy_init) else $error("idle before init");
  property p_wr_oe;
    o_mem_dq_oe[0] == (cmd == fbm_pkg::CMD_WR);
  endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("data driven off write");
endmodule
bind fbm_mem_port fbm_mem_port_chk chk_inst (
  .i_mclk, .i_rstn, .i_num_ports, .i_bypass, .i_use_pll, .i_byp_valid, .i_byp_data,
  .o_mem_cs_n, .o_mem_ras_n, .o_mem_cas_n, .o_mem_we_n, .o_mem_dqm, .o_mem_dq_oe,
  .o_rd_valid, .o_rd_busy, .o_byp_data, .o_byp_valid, .o_init_done, .o_mem_clk_mult
);
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        i_mclk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1, i_sgram_mode = 1'b0;
  logic [2:0]  i_num_ports = 3'h4;
  logic        i_high_speed_channel_grade = 1'b0, i_bypass = 1'b0, i_use_pll = 1'b0;
  logic [4:0]  i_pll_prediv = 5'h01;
  logic        i_wr_valid = 1'b0, i_rd_req = 1'b0, i_byp_valid = 1'b0;
  logic [63:0] i_wr_data = 64'h0, i_byp_data = 64'h0, o_rd_data, o_byp_data, i_mem_dq;
  logic [63:0] o_mem_dq, o_mem_dq_oe;
  logic [21:0] i_wr_addr = 22'h0, i_rd_addr = 22'h0;
  logic        o_wr_ready, o_rd_busy, o_rd_valid, o_byp_valid, o_mem_cke, o_init_done;
  logic [3:0]  o_mem_cs_n;
  logic        o_mem_ras_n, o_mem_cas_n, o_mem_we_n;
  logic [1:0]  o_mem_ba;
  logic [12:0] o_mem_a;
  logic [7:0]  o_mem_dqm;
  logic [8:0]  o_mem_clk_mult;
  int          error_cnt = 0;
  int          checks_done = 0;
  always #5 i_mclk = ~i_mclk;
  // short power-up so the buffer can be filled while init still runs
  fbm_mem_port #(.POWERUP_CYCLES(40), .REFI_CYCLES(50), .FIFO_DEPTH(8)) fbm_mem_port_inst (
    .i_mclk, .i_rstn, .i_ce, .i_sgram_mode, .i_num_ports, .i_high_speed_channel_grade,
    .i_bypass, .i_use_pll, .i_pll_prediv, .i_wr_valid, .i_wr_data, .i_wr_addr, .o_wr_ready,
    .i_rd_req, .i_rd_addr, .o_rd_busy, .o_rd_valid, .o_rd_data, .i_byp_data, .i_byp_valid,
    .o_byp_data, .o_byp_valid, .o_mem_cke, .o_mem_cs_n, .o_mem_ras_n, .o_mem_cas_n,
    .o_mem_we_n, .o_mem_ba, .o_mem_a, .o_mem_dqm, .i_mem_dq, .o_mem_dq, .o_mem_dq_oe,
    .o_init_done, .o_mem_clk_mult);
  fbm_sdram_mdl mdl_inst (.i_mclk, .i_cs_n(o_mem_cs_n), .i_ras_n(o_mem_ras_n),
    .i_cas_n(o_mem_cas_n), .i_we_n(o_mem_we_n), .i_ba(o_mem_ba), .i_a(o_mem_a),
    .i_dqm(o_mem_dqm), .i_dq(o_mem_dq), .o_dq(i_mem_dq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input bit hit);
    if (hit) begin
      error_cnt++;
      $display("[FAIL] wait expected done seen timeout");
      tally_and_finish();
    end
  endtask
  task automatic wait_busy(input bit lvl);
    int n;
    n = 0;
    while (o_rd_busy !== lvl && n < 500) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    tmo(n >= 500);
  endtask
  // wt: follow the pop through so the held address is the one written
  task automatic push(input logic [21:0] a, input logic [63:0] d, input bit wt);
    int n;
    @(posedge i_mclk);
    i_wr_valid <= 1'b1;
    i_wr_data <= d;
    i_wr_addr <= a;
    n = 0;
    #1;
    while (o_wr_ready !== 1'b1 && n < 500) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    tmo(n >= 500);
    @(posedge i_mclk);
    i_wr_valid <= 1'b0;
    if (wt) begin
      #1;
      wait_busy(1'b1);
      wait_busy(1'b0);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [21:0] a, input logic [63:0] e);
    int n;
    @(posedge i_mclk);
    i_rd_req <= 1'b1;
    i_rd_addr <= a;
    n = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
    end while (o_rd_valid !== 1'b1 && n < 2000);
    tmo(n >= 2000);
    check(nm, o_rd_data, e);
    @(posedge i_mclk);
    i_rd_req <= 1'b0;
    #1;
    wait_busy(1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("cs_n_rst", {60'h0, o_mem_cs_n}, 64'hF);
    check("cke_rst", {63'h0, o_mem_cke}, 64'h0);
    check("oe_rst", o_mem_dq_oe, 64'h0);
    check("busy_rst", {62'h0, o_rd_busy, o_init_done}, 64'h2);
    $display("test reset done");
  endtask
  task automatic t_fill();
    int n;
    for (int i = 1; i <= 8; i++) begin
      push(22'h000104, 64'hC3C3_5A5A_0F0F_F000 | 64'(i), 1'b0);
    end
    #1;
    check("wr_ready_full", {63'h0, o_wr_ready}, 64'h0);
    check("init_in_fill", {63'h0, o_init_done}, 64'h0);
    n = 0;
    while (o_init_done !== 1'b1 && n < 2000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    tmo(n >= 2000);
    check("cke_run", {63'h0, o_mem_cke}, 64'h1);
    rd_chk("fill_last", 22'h000104, 64'hC3C3_5A5A_0F0F_F008);
    $display("test fill done");
  endtask
  task automatic t_refresh();
    int cnt;
    cnt = 0;
    for (int i = 0; i < 160; i++) begin
      @(posedge i_mclk);
      #1;
      cnt += ({o_mem_cs_n[0], o_mem_ras_n, o_mem_cas_n, o_mem_we_n} == fbm_pkg::CMD_REF);
    end
    check("refresh_count", {63'h0, cnt >= 3 && cnt <= 4}, 64'h1);
    $display("test refresh done");
  endtask
  task automatic t_map4();
    push(22'h012345, 64'h0123_4567_89AB_CDEF, 1'b1);
    check("lane_map", mdl_inst.last_wr, 64'h0123_4567_89AB_CDEF);
    rd_chk("rd_4port", 22'h012345, 64'h0123_4567_89AB_CDEF);
    $display("test map4 done");
  endtask
  task automatic t_ports2();
    @(posedge i_mclk);
    i_num_ports <= 3'h2;
    push(22'h002040, 64'hFEDC_BA98_7654_3210, 1'b1);
    rd_chk("rd_2port", 22'h002040, 64'h0000_0000_7654_3210);
    @(posedge i_mclk);
    i_num_ports <= 3'h4;
    $display("test ports2 done");
  endtask
  task automatic t_half();
    push(22'h200080, 64'h1111_2222_3333_4444, 1'b1);
    rd_chk("rd_alias", 22'h000080, 64'h1111_2222_3333_4444);
    $display("test half done");
  endtask
  task automatic t_sgram();
    @(posedge i_mclk);
    i_sgram_mode <= 1'b1;
    i_high_speed_channel_grade <= 1'b1;
    push(22'h000333, 64'h8765_4321_0FED_CBA9, 1'b1);
    rd_chk("rd_sgram", 22'h000333, 64'h8765_4321_0FED_CBA9);
    @(posedge i_mclk);
    i_sgram_mode <= 1'b0;
    $display("test sgram done");
  endtask
  task automatic t_bypass();
    int cnt;
    @(posedge i_mclk);
    i_bypass <= 1'b1;
    i_byp_valid <= 1'b1;
    i_byp_data <= 64'hDEAD_BEEF_0BAD_F00D;
    i_rd_req <= 1'b1;
    @(posedge i_mclk);
    i_byp_valid <= 1'b0;
    #1;
    check("byp_data", o_byp_data, 64'hDEAD_BEEF_0BAD_F00D);
    check("byp_valid", {63'h0, o_byp_valid}, 64'h1);
    cnt = 0;
    for (int i = 0; i < 30; i++) begin
      @(posedge i_mclk);
      #1;
      cnt += o_rd_valid;
    end
    check("byp_rd_refused", 64'(cnt), 64'h0);
    @(posedge i_mclk);
    i_rd_req <= 1'b0;
    @(posedge i_mclk);
    i_bypass <= 1'b0;
    $display("test bypass done");
  endtask
  task automatic t_pll();
    @(posedge i_mclk);
    i_use_pll <= 1'b1;
    i_pll_prediv <= 5'h03;
    repeat (2) @(posedge i_mclk);
    #1;
    check("pll_mult", {55'h0, o_mem_clk_mult}, 64'h10);
    @(posedge i_mclk);
    i_use_pll <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    check("ext_mult", {55'h0, o_mem_clk_mult}, 64'h0);
    $display("test pll done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_mclk);
    #1;
    t_reset();
    @(posedge i_mclk);
    i_rstn <= 1'b1;
    t_fill();
    t_refresh();
    t_map4();
    t_ports2();
    t_half();
    t_sgram();
    t_bypass();
    t_pll();
    tally_and_finish();
  end
endmodule
`default_nettype wire
